// File: host_adapter_diag_config_cmds.sv
// Diagnostic and configuration command handler with AXI4-Lite register access
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module host_adapter_diag_config_cmds #(
   parameter logic [host_adapter_pkg::EE_BYTES-1:0][7:0] FACTORY_CFG = '0
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire host_adapter_pkg::axil_req_t AXI_REQ,
   output host_adapter_pkg::axil_rsp_t AXI_RSP,
   output host_adapter_pkg::cfg_out_t CFG_OUT
);
   import host_adapter_pkg::*;

   typedef struct packed {
      state_t fsm;
      logic [7:0] opcode;
      logic [7:0] pidx;
      logic [7:0] plen;
      logic flag;
      logic [4:0] offset;
      logic [5:0] nbytes;
      logic [DIAG_CNT_W-1:0] dcnt;
      logic [7:0] data_in;
      logic df;
      logic diag_fail;
      logic self_test;
      logic done;
      logic any_int;
      logic [1:0] shadow;
      logic [7:0] disc;
      logic [7:0] diag_inject;
      logic [EE_BYTES-1:0][7:0] nv;
      logic [EE_BYTES-1:0][7:0] live;
      logic aw_full;
      logic [7:0] awaddr;
      logic w_full;
      logic [7:0] wbyte;
      logic wlane0;
      axil_rsp_t rsp;
      cfg_out_t cfg;
   } regs_t;

   regs_t r_reg;
   regs_t r_next;
   logic rst_meta_reg;
   logic rst_sync_reg;
   logic wr_fire;
   logic rd_fire;
   logic wr_mapped;
   logic cmd_pulse;
   logic pop;
   logic status_idle;

   // Byte pick from the factory or live image
   function automatic logic [7:0] cfg_byte(input logic use_live,
                                           input logic [EE_BYTES-1:0][7:0] live,
                                           input logic [4:0] idx);
      cfg_byte = use_live ? live[idx] : FACTORY_CFG[idx];
   endfunction

   // Reset release through two stages; assertion is still immediate
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // Write strobes decoded from held address and data, read strobes from the live request
   assign wr_fire = r_reg.aw_full && r_reg.w_full && !r_reg.rsp.bvalid;
   assign rd_fire = AXI_REQ.arvalid && r_reg.rsp.arready;
   assign wr_mapped = (r_reg.awaddr == OFS_STATUS) || (r_reg.awaddr == OFS_DATA) ||
                      (r_reg.awaddr == OFS_INT_FLAGS) || (r_reg.awaddr == OFS_SHADOW) ||
                      (r_reg.awaddr == OFS_DIAG_INJECT) || (r_reg.awaddr == OFS_DISC_MAP);
   assign cmd_pulse = wr_fire && r_reg.wlane0 && (r_reg.awaddr == OFS_DATA);
   assign pop = rd_fire && (AXI_REQ.araddr == OFS_DATA);
   assign status_idle = (r_reg.fsm == S_IDLE) && !r_reg.self_test;

   // Next-state logic for bus slave and command sequencer
   always_comb begin
      logic [31:0] rd;
      logic finish;
      rd = 32'h0;
      finish = 1'b0;
      r_next = r_reg;

      // Response channels retire on handshake
      if (r_reg.rsp.bvalid && AXI_REQ.bready) begin
         r_next.rsp.bvalid = 1'b0;
      end
      if (r_reg.rsp.rvalid && AXI_REQ.rready) begin
         r_next.rsp.rvalid = 1'b0;
      end
      // Address and data may arrive in either order
      if (AXI_REQ.awvalid && r_reg.rsp.awready) begin
         r_next.aw_full = 1'b1;
         r_next.awaddr = AXI_REQ.awaddr;
      end
      if (AXI_REQ.wvalid && r_reg.rsp.wready) begin
         r_next.w_full = 1'b1;
         r_next.wbyte = AXI_REQ.wdata[7:0];
         r_next.wlane0 = AXI_REQ.wstrb[0];
      end
      if (wr_fire) begin
         r_next.aw_full = 1'b0;
         r_next.w_full = 1'b0;
         r_next.rsp.bvalid = 1'b1;
         r_next.rsp.bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
         // Clear first so a same-cycle hardware set wins
         if (r_reg.wlane0 && r_reg.awaddr == OFS_INT_FLAGS) begin
            if (r_reg.wbyte[IF_CMD_DONE]) begin
               r_next.done = 1'b0;
            end
            if (r_reg.wbyte[IF_ANY_INT]) begin
               r_next.any_int = 1'b0;
            end
         end
         if (r_reg.wlane0 && r_reg.awaddr == OFS_DIAG_INJECT) begin
            r_next.diag_inject = r_reg.wbyte;
         end
      end

      // Read mux; data-in read also drains the byte
      case (AXI_REQ.araddr)
         OFS_STATUS: begin
            rd[ST_SELF_TEST] = r_reg.self_test;
            rd[ST_DIAG_FAIL] = r_reg.diag_fail;
            rd[ST_IDLE] = status_idle;
            rd[ST_DATA_IN_FULL] = r_reg.df;
         end
         OFS_DATA: rd[7:0] = r_reg.data_in;
         OFS_INT_FLAGS: begin
            rd[IF_CMD_DONE] = r_reg.done;
            rd[IF_ANY_INT] = r_reg.any_int;
         end
         OFS_SHADOW: rd[1:0] = r_reg.shadow;
         OFS_DIAG_INJECT: rd[7:0] = r_reg.diag_inject;
         OFS_DISC_MAP: rd[7:0] = r_reg.disc;
         default: rd = 32'h0;
      endcase
      if (rd_fire) begin
         r_next.rsp.rvalid = 1'b1;
         r_next.rsp.rdata = rd;
         r_next.rsp.rresp = (AXI_REQ.araddr > OFS_DISC_MAP || AXI_REQ.araddr[1:0] != 2'b00) ?
                            RESP_SLVERR : RESP_OKAY;
      end
      if (pop) begin
         r_next.df = 1'b0;
      end

      // Command sequencer
      case (r_reg.fsm)
         S_IDLE: begin
            if (cmd_pulse) begin
               r_next.opcode = r_reg.wbyte;
               r_next.pidx = 8'h00;
               case (r_reg.wbyte)
                  OP_ECHO, OP_OPTIONS, OP_EE_WRITE, OP_EE_READ, OP_SHADOW: begin
                     r_next.fsm = S_PARAM;
                  end
                  OP_DIAG: begin
                     r_next.fsm = S_DIAG;
                     r_next.self_test = 1'b1;
                     r_next.diag_fail = 1'b0;
                     r_next.df = 1'b0;
                     r_next.dcnt = '0;
                  end
                  default: r_next.fsm = S_IDLE; // Unknown opcode dropped
               endcase
            end
         end
         S_PARAM: begin
            if (cmd_pulse) begin
               r_next.pidx = r_reg.pidx + 8'h01;
               case (r_reg.opcode)
                  OP_ECHO: begin
                     r_next.data_in = r_reg.wbyte;
                     r_next.df = 1'b1;
                     r_next.fsm = S_ECHO;
                  end
                  OP_OPTIONS: begin
                     // Trailing bytes beyond the bitmap fall through unused
                     if (r_reg.pidx == 8'h00) begin
                        r_next.plen = r_reg.wbyte;
                        finish = (r_reg.wbyte == 8'h00);
                     end else begin
                        if (r_reg.pidx == 8'h01) begin
                           r_next.disc = r_reg.wbyte;
                        end
                        finish = (r_reg.pidx == r_reg.plen);
                     end
                  end
                  OP_EE_WRITE: begin
                     if (r_reg.pidx == 8'h01) begin
                        r_next.nbytes = (r_reg.wbyte > EE_MAX_XFER) ?
                                        EE_MAX_XFER[5:0] : r_reg.wbyte[5:0];
                     end else if (r_reg.pidx == 8'h02) begin
                        r_next.offset = r_reg.wbyte[4:0];
                        finish = (r_reg.nbytes == 6'h00);
                     end else if (r_reg.pidx > 8'h02) begin
                        // Offset wraps inside the store, so 32 from zero fills it
                        r_next.nv[r_reg.offset] = r_reg.wbyte;
                        r_next.live[r_reg.offset] = r_reg.wbyte;
                        r_next.offset = r_reg.offset + 5'h01;
                        finish = (r_reg.pidx == {2'b00, r_reg.nbytes} + 8'h02);
                     end
                  end
                  OP_EE_READ: begin
                     if (r_reg.pidx == 8'h00) begin
                        r_next.flag = r_reg.wbyte[0];
                     end else if (r_reg.pidx == 8'h01) begin
                        r_next.nbytes = (r_reg.wbyte > EE_MAX_XFER) ?
                                        EE_MAX_XFER[5:0] : r_reg.wbyte[5:0];
                     end else begin
                        if (r_reg.nbytes == 6'h00) begin
                           finish = 1'b1;
                        end else begin
                           r_next.data_in = cfg_byte(r_reg.flag, r_reg.live,
                                                     r_reg.wbyte[4:0]);
                           r_next.offset = r_reg.wbyte[4:0] + 5'h01;
                           r_next.nbytes = r_reg.nbytes - 6'h01;
                           r_next.df = 1'b1;
                           r_next.fsm = S_RETURN;
                        end
                     end
                  end
                  OP_SHADOW: begin
                     r_next.shadow = r_reg.wbyte[1:0];
                     r_next.done = 1'b1;
                     r_next.fsm = S_IDLE;
                  end
                  default: r_next.fsm = S_IDLE;
               endcase
            end
         end
         S_ECHO: begin
            if (pop) begin
               finish = 1'b1;
            end
         end
         S_RETURN: begin
            if (pop) begin
               if (r_reg.nbytes == 6'h00) begin
                  finish = 1'b1;
               end else begin
                  // Next byte is staged in the same cycle as the drain
                  r_next.data_in = cfg_byte(r_reg.flag, r_reg.live, r_reg.offset);
                  r_next.offset = r_reg.offset + 5'h01;
                  r_next.nbytes = r_reg.nbytes - 6'h01;
                  r_next.df = 1'b1;
               end
            end
         end
         S_DIAG: begin
            r_next.dcnt = r_reg.dcnt + {{(DIAG_CNT_W-1){1'b0}}, 1'b1};
            if (r_reg.dcnt == DIAG_CNT_W'(DIAG_CYCLES - 1)) begin
               r_next.self_test = 1'b0;
               // Internal hard reset; host reprograms options afterward
               r_next.live = r_reg.nv;
               r_next.disc = DISC_RST;
               if (r_reg.diag_inject != 8'h00) begin
                  r_next.diag_fail = 1'b1;
                  r_next.data_in = r_reg.diag_inject;
                  r_next.df = 1'b1;
               end
               finish = 1'b1;
            end
         end
         default: r_next.fsm = S_IDLE;
      endcase

      if (finish) begin
         r_next.done = 1'b1;
         r_next.any_int = 1'b1;
         r_next.fsm = S_IDLE;
      end

      // Ready flags track holding state so each can sit in a flop
      r_next.rsp.awready = !r_next.aw_full && !r_next.rsp.bvalid;
      r_next.rsp.wready = !r_next.w_full && !r_next.rsp.bvalid;
      r_next.rsp.arready = !r_next.rsp.rvalid;
      r_next.cfg.shadow_read_ram = r_next.shadow[1];
      r_next.cfg.shadow_write_en = (r_next.shadow == SH_RAM_RW);
      r_next.cfg.disconnect_mask = r_next.disc;
   end

   // State register
   always_ff @(posedge CLK or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         r_reg <= '0;
         r_reg.fsm <= S_IDLE;
         r_reg.shadow <= SHADOW_RST;
         r_reg.disc <= DISC_RST;
         r_reg.nv <= FACTORY_CFG;
         r_reg.live <= FACTORY_CFG;
      end else begin
         r_reg <= r_next;
      end
   end

   assign AXI_RSP = r_reg.rsp;
   assign CFG_OUT = r_reg.cfg;

   // Checks
   localparam int AST_DIAG_LO = DIAG_CYCLES;
   localparam int AST_DIAG_HI = DIAG_CYCLES + 1;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!rst_sync_reg);

   AST_ECHO_RETURN: assert property (
      (r_reg.fsm == S_PARAM && r_reg.opcode == OP_ECHO && cmd_pulse) |=>
      (r_reg.df && r_reg.data_in == $past(r_reg.wbyte) && r_reg.fsm == S_ECHO))
      else $error("echo byte not returned");

   AST_ECHO_DONE_AFTER_READ: assert property (
      (r_reg.fsm == S_ECHO && !pop && !r_reg.done) |=> !r_reg.done)
      else $error("echo done before host read");

   AST_DIAG_LENGTH: assert property (
      (r_reg.fsm == S_IDLE && cmd_pulse && r_reg.wbyte == OP_DIAG) |=>
      r_reg.self_test ##[AST_DIAG_LO:AST_DIAG_HI] (!r_reg.self_test && r_reg.fsm == S_IDLE))
      else $error("self-test duration wrong");

   AST_DIAG_ACTIVE_HOLD: assert property (
      (r_reg.fsm == S_DIAG) |-> (r_reg.self_test && !status_idle))
      else $error("self-test flag dropped early");

   AST_DIAG_PASS: assert property (
      ($fell(r_reg.self_test) && $past(r_reg.diag_inject) == 8'h00) |->
      (status_idle && !r_reg.diag_fail && !r_reg.df))
      else $error("passing diagnostic misreported");

   AST_DIAG_FAIL_CODE: assert property (
      ($fell(r_reg.self_test) && $past(r_reg.diag_inject) != 8'h00) |->
      (r_reg.df && r_reg.diag_fail && r_reg.data_in == $past(r_reg.diag_inject)))
      else $error("failing test number missing");

   AST_DIAG_FLAGS: assert property (
      $fell(r_reg.self_test) |-> (r_reg.done && r_reg.any_int))
      else $error("diagnostic end flags missing");

   AST_DISC_MAP: assert property (
      (r_reg.fsm == S_PARAM && r_reg.opcode == OP_OPTIONS && r_reg.pidx == 8'h01 &&
       cmd_pulse) |=> (CFG_OUT.disconnect_mask == $past(r_reg.wbyte)))
      else $error("disconnect bitmap not applied");

   AST_EE_BOTH: assert property (
      (r_reg.fsm == S_PARAM && r_reg.opcode == OP_EE_WRITE && r_reg.pidx > 8'h02 &&
       cmd_pulse) |=> (r_reg.nv[$past(r_reg.offset)] == $past(r_reg.wbyte) &&
       r_reg.live[$past(r_reg.offset)] == $past(r_reg.wbyte)))
      else $error("config write not mirrored");

   AST_SHADOW_NO_INT: assert property (
      (r_reg.fsm == S_PARAM && r_reg.opcode == OP_SHADOW && cmd_pulse && !r_reg.any_int) |=>
      (r_reg.done && !r_reg.any_int))
      else $error("shadow command raised interrupt");

   AST_SHADOW_DECODE: assert property (
      CFG_OUT.shadow_write_en |-> (CFG_OUT.shadow_read_ram && r_reg.shadow == SH_RAM_RW))
      else $error("shadow write enable wrong");

   COV_ECHO: cover property (
      (r_reg.fsm == S_ECHO) ##[1:50] (r_reg.fsm == S_IDLE && r_reg.done));
   COV_DIAG_FAIL: cover property ($fell(r_reg.self_test) && r_reg.diag_fail);
   COV_EE_READ: cover property ((r_reg.fsm == S_RETURN) ##[1:50] (r_reg.fsm == S_IDLE));
   COV_SHADOW_RW: cover property ($rose(CFG_OUT.shadow_write_en));
endmodule

// File: host_adapter_diag_config_cmds_tb.sv
// Self-checking bench for the diagnostic and configuration command handler
`timescale 1ns/100ps
module host_adapter_diag_config_cmds_tb;
   import host_adapter_pkg::*;

   logic CLK = 1'b0;
   logic RST_N = 1'b0;
   axil_req_t req;
   axil_rsp_t rsp;
   cfg_out_t cfg;
   int fail_count = 0;
   int n_compared = 0;
   logic [31:0] v;
   logic [1:0] resp;

   // 40 MHz clock
   always #12.5 CLK = ~CLK;

   host_adapter_diag_config_cmds host_adapter_diag_config_cmds_inst (
      .CLK(CLK),
      .RST_N(RST_N),
      .AXI_REQ(req),
      .AXI_RSP(rsp),
      .CFG_OUT(cfg)
   );

   host_cpu_model host_cpu_model_inst (
      .clk(CLK),
      .req(req),
      .rsp(rsp)
   );

   // Compare and count
   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
      host_cpu_model_inst.rd(a, v, resp);
      chk(name, v & m, exp);
   endtask

   // One command byte per data-port write, opcode first
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) begin
         host_cpu_model_inst.wr(OFS_DATA, {24'h0, b[i]}, resp);
         chk("data write resp", {30'h0, resp}, {30'h0, RESP_OKAY});
      end
   endtask

   task automatic clr();
      host_cpu_model_inst.wr(OFS_INT_FLAGS, 32'h81, resp);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (5) @(posedge CLK);
      rd_chk("shadow after reset", OFS_SHADOW, 32'hffffffff, 32'h0);
      chk("shadow pins after reset", {30'h0, cfg.shadow_read_ram, cfg.shadow_write_en}, 0);
      // Echo: done must wait for the host read
      send({OP_ECHO, 8'ha5});
      rd_chk("echo full", OFS_STATUS, 32'h4, 32'h4);
      rd_chk("echo done early", OFS_INT_FLAGS, 32'h1, 32'h0);
      rd_chk("echo data", OFS_DATA, 32'hff, 32'ha5);
      rd_chk("echo done", OFS_INT_FLAGS, 32'h81, 32'h81);
      clr();
      // Options with two surplus bytes that must be dropped
      send({OP_OPTIONS, 8'h03, 8'h5a, 8'hff, 8'h0f});
      chk("disconnect pins", {24'h0, cfg.disconnect_mask}, 32'h5a);
      rd_chk("disconnect reg", OFS_DISC_MAP, 32'hffffffff, 32'h5a);
      rd_chk("options done", OFS_INT_FLAGS, 32'h1, 32'h1);
      clr();
      // Partial config write near the top, count is 31 minus offset
      send({OP_EE_WRITE, 8'h00, 8'h02, 8'h1d, 8'h11, 8'h22});
      rd_chk("ee write done", OFS_INT_FLAGS, 32'h1, 32'h1);
      clr();
      send({OP_EE_READ, 8'h01, 8'h02, 8'h1d});
      rd_chk("ee live 0", OFS_DATA, 32'hff, 32'h11);
      rd_chk("ee live 1", OFS_DATA, 32'hff, 32'h22);
      rd_chk("ee read empty", OFS_STATUS, 32'h4, 32'h0);
      rd_chk("ee read done", OFS_INT_FLAGS, 32'h1, 32'h1);
      clr();
      send({OP_EE_READ, 8'h00, 8'h01, 8'h1d});
      rd_chk("ee default", OFS_DATA, 32'hff, 32'h0);
      clr();
      // Every shadow code, done without any-interrupt
      for (int c = 0; c < 4; c++) begin
         send({OP_SHADOW, 8'(c)});
         rd_chk("shadow code", OFS_SHADOW, 32'h3, c);
         chk("shadow read ram", {31'h0, cfg.shadow_read_ram}, {31'h0, c[1]});
         chk("shadow write", {31'h0, cfg.shadow_write_en}, {31'h0, c == 3});
         rd_chk("shadow flags", OFS_INT_FLAGS, 32'h81, 32'h1);
         clr();
      end
      // Diagnostic pass, then a failure reporting test number 5
      for (int f = 0; f < 2; f++) begin
         host_cpu_model_inst.wr(OFS_DIAG_INJECT, f ? 32'h5 : 32'h0, resp);
         send({OP_DIAG});
         rd_chk("self test active", OFS_STATUS, 32'h80, 32'h80);
         repeat (DIAG_CYCLES + 20) @(posedge CLK);
         rd_chk("diag status", OFS_STATUS, 32'hd4, f ? 32'h54 : 32'h10);
         rd_chk("diag flags", OFS_INT_FLAGS, 32'h81, 32'h81);
         if (f) rd_chk("diag code", OFS_DATA, 32'hff, 32'h5);
         else chk("bitmap after hard reset", {24'h0, cfg.disconnect_mask}, 32'h0);
         // Host reinitialises the options before further traffic
         clr();
         send({OP_OPTIONS, 8'h01, 8'h3c});
         chk("reinit bitmap", {24'h0, cfg.disconnect_mask}, 32'h3c);
         clr();
      end
      // Unmapped address answers with an error on both channels
      host_cpu_model_inst.rd(8'h40, v, resp);
      chk("unmapped resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
      chk("unmapped data", v, 32'h0);
      host_cpu_model_inst.wr(8'h40, 32'h0, resp);
      chk("unmapped write resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
      give_verdict();
   end

   // Watchdog, far beyond the expected run of roughly a thousand cycles
   initial begin
      repeat (20000) @(posedge CLK);
      fail_count++;
      $display("mismatch watchdog expected finish seen timeout");
      give_verdict();
   end
endmodule

// File: host_adapter_pkg.sv
// Shared constants and types for the host adapter command handler
package host_adapter_pkg;

   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_INT_FLAGS = 8'h08;
   localparam logic [7:0] OFS_SHADOW = 8'h0c;
   localparam logic [7:0] OFS_DIAG_INJECT = 8'h10;
   localparam logic [7:0] OFS_DISC_MAP = 8'h14;

   // Command opcodes
   localparam logic [7:0] OP_ECHO = 8'h1f;
   localparam logic [7:0] OP_DIAG = 8'h20;
   localparam logic [7:0] OP_OPTIONS = 8'h21;
   localparam logic [7:0] OP_EE_WRITE = 8'h22;
   localparam logic [7:0] OP_EE_READ = 8'h23;
   localparam logic [7:0] OP_SHADOW = 8'h24;

   // Status register bit positions
   localparam int ST_SELF_TEST = 7;
   localparam int ST_DIAG_FAIL = 6;
   localparam int ST_IDLE = 4;
   localparam int ST_DATA_IN_FULL = 2;

   // Interrupt flag register bit positions
   localparam int IF_ANY_INT = 7;
   localparam int IF_CMD_DONE = 0;

   // Configuration store geometry
   localparam int EE_BYTES = 32;
   localparam logic [7:0] EE_MAX_XFER = 8'h20;

   // Self-test duration
   localparam int CLK_PERIOD_NS = 25;
   localparam int DIAG_TIME_NS = 10000;
   localparam int DIAG_CYCLES = (DIAG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIAG_CNT_W = $clog2(DIAG_CYCLES + 1);

   // Reset values
   localparam logic [1:0] SHADOW_RST = 2'b00;
   localparam logic [7:0] DISC_RST = 8'h00;

   // Shadow codes and bus responses
   localparam logic [1:0] SH_RAM_RW = 2'b11;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_PARAM = 3'b001,
      S_ECHO = 3'b010,
      S_DIAG = 3'b011,
      S_RETURN = 3'b100
   } state_t;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_t;

   typedef struct packed {
      logic shadow_read_ram;
      logic shadow_write_en;
      logic [7:0] disconnect_mask;
   } cfg_out_t;

endpackage

// File: host_cpu_model.sv
// Host CPU model: AXI4-Lite master issuing one register access at a time
`timescale 1ns/100ps
module host_cpu_model (
   input wire logic clk,
   output host_adapter_pkg::axil_req_t req,
   input wire host_adapter_pkg::axil_rsp_t rsp
);
   import host_adapter_pkg::*;

   axil_rsp_t seen;

   // Bus idle from time zero
   initial begin
      req = '0;
   end

   // Sample mid-cycle so the value seen at the rising edge never races the flops
   always @(negedge clk) begin
      seen <= rsp;
   end

   // Write: address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      // No cycle budget here; only the bench watchdog ends a stuck wait
      do begin
         @(posedge clk);
         if (seen.awready && req.awvalid) req.awvalid <= 1'b0;
         if (seen.wready && req.wvalid) req.wvalid <= 1'b0;
      end while (!(seen.bvalid && req.bready));
      r = seen.bresp;
      req.bready <= 1'b0;
      // Idle edge so the next access never reassigns bready in the same step
      @(posedge clk);
   endtask

   // Read: address held until taken, rready held until data arrives
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do begin
         @(posedge clk);
         if (seen.arready && req.arvalid) req.arvalid <= 1'b0;
      end while (!(seen.rvalid && req.rready));
      d = seen.rdata;
      r = seen.rresp;
      req.rready <= 1'b0;
      @(posedge clk);
   endtask
endmodule
